// File: core/link_rx_end.sv
// receiving end: rebuilds words, buffers each channel, returns credits
`timescale 1ns/1ps
module link_rx_end
	import chip_link_pkg::*;
#(
	parameter int RX_DEPTH = RX_DEPTH_DEF
) (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	chip_link_if.rx_end            link,
	input  wire logic [1:0]        link_mode,
	input  wire logic [NUM_CH-1:0] drain_ready,
	output logic                   recv_valid,
	output logic [1:0]             recv_chan,
	output logic [WORD_W-1:0]      recv_data
);
	localparam int AW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
	localparam int CW = $clog2(RX_DEPTH + 1);

	logic              half_reg,    half_next;
	logic [HALF_W-1:0] lo_reg,      lo_next;
	logic [WORD_W-1:0] mem_reg  [NUM_CH][RX_DEPTH];
	logic [WORD_W-1:0] mem_next [NUM_CH][RX_DEPTH];
	logic [AW-1:0]     wr_reg   [NUM_CH];
	logic [AW-1:0]     wr_next  [NUM_CH];
	logic [AW-1:0]     rd_reg   [NUM_CH];
	logic [AW-1:0]     rd_next  [NUM_CH];
	logic [CW-1:0]     cnt_reg  [NUM_CH];
	logic [CW-1:0]     cnt_next [NUM_CH];
	logic              valid_reg,   valid_next;
	logic [1:0]        chan_reg,    chan_next;
	logic [WORD_W-1:0] data_reg,    data_next;
	logic [NUM_CH-1:0] credit_reg,  credit_next;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		return (p == AW'(RX_DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	always_comb begin
		logic              push;
		logic              pop;
		logic [1:0]        pidx;
		logic [1:0]        sidx;
		logic [WORD_W-1:0] pword;
		push        = 1'b0;
		pop         = 1'b0;
		pidx        = 2'h0;
		sidx        = 2'h0;
		pword       = '0;
		half_next   = half_reg;
		lo_next     = lo_reg;
		mem_next    = mem_reg;
		wr_next     = wr_reg;
		rd_next     = rd_reg;
		cnt_next    = cnt_reg;
		data_next   = data_reg;
		credit_next = '0;
		if (link.state != ST_NONE) begin
			pidx = chan_idx(link.state);
			if (half_reg) begin
				// upper half always follows on the very next cycle
				push      = 1'b1;
				pword     = {link.data[HALF_W-1:0], lo_reg};
				half_next = 1'b0;
			end else begin
				case (link_mode)
					MODE_NARROW: begin
						if (link.fit) begin
							push  = 1'b1;
							pword = {{HALF_W{link.data[HALF_W-1]}}, link.data[HALF_W-1:0]};
						end else begin
							half_next = 1'b1;
							lo_next   = link.data[HALF_W-1:0];
						end
					end
					MODE_HALF: begin
						half_next = 1'b1;
						lo_next   = link.data[HALF_W-1:0];
					end
					default: begin
						push  = 1'b1;
						pword = link.data;
					end
				endcase
			end
		end
		// lowest channel wins when several are ready to drain
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (cnt_reg[i] != '0 && drain_ready[i]) begin
				pop  = 1'b1;
				sidx = 2'(i);
			end
		end
		valid_next = pop;
		chan_next  = pop ? idx_state(sidx) : ST_NONE;
		if (pop) begin
			data_next         = mem_reg[sidx][rd_reg[sidx]];
			rd_next[sidx]     = ptr_inc(rd_reg[sidx]);
			credit_next[sidx] = 1'b1;
		end
		if (push) begin
			// no overflow guard: the sender's credits keep us in range
			mem_next[pidx][wr_reg[pidx]] = pword;
			wr_next[pidx]                = ptr_inc(wr_reg[pidx]);
		end
		for (int i = 0; i < NUM_CH; i++) begin
			cnt_next[i] = cnt_reg[i] + CW'(push && pidx == 2'(i)) - CW'(pop && sidx == 2'(i));
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			half_reg   <= 1'b0;
			lo_reg     <= '0;
			valid_reg  <= 1'b0;
			chan_reg   <= ST_NONE;
			data_reg   <= '0;
			credit_reg <= '0;
			for (int i = 0; i < NUM_CH; i++) begin
				wr_reg[i]  <= '0;
				rd_reg[i]  <= '0;
				cnt_reg[i] <= '0;
				for (int j = 0; j < RX_DEPTH; j++) begin
					mem_reg[i][j] <= '0;
				end
			end
		end else begin
			half_reg   <= half_next;
			lo_reg     <= lo_next;
			valid_reg  <= valid_next;
			chan_reg   <= chan_next;
			data_reg   <= data_next;
			credit_reg <= credit_next;
			mem_reg    <= mem_next;
			wr_reg     <= wr_next;
			rd_reg     <= rd_next;
			cnt_reg    <= cnt_next;
		end
	end

	assign link.credit = credit_reg;
	assign recv_valid  = valid_reg;
	assign recv_chan   = chan_reg;
	assign recv_data   = data_reg;
endmodule

// File: core/link_tx_end.sv
// sending end: credit-gated channel mux, width modes and commit buffer
`timescale 1ns/1ps
// What this block does
// - three channels share one 32-bit path
// - state 0 idle, 1 static, 2 mem, 3 low
// - separate credit line per channel
// - narrow mode: signed 16 bits plus fit flag
// - no fit: upper half next cycle, rejoined
// - half mode: every word over two cycles
// - extra hop cycle tolerated via credits
// - commit-buffer dynamic message sent unbroken
// - software disables interrupts for uncommitted sends
module link_tx_end
	import chip_link_pkg::*;
#(
	parameter int CREDITS  = RX_DEPTH_DEF,
	parameter int CB_DEPTH = CB_DEPTH_DEF
) (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	chip_link_if.tx_end            link,
	input  wire logic [1:0]        link_mode,
	input  wire logic              send_valid,
	input  wire logic [1:0]        send_chan,
	input  wire logic [WORD_W-1:0] send_data,
	output logic [NUM_CH-1:0]      send_ready,
	input  wire logic              commit_valid,
	input  wire logic [1:0]        commit_chan,
	input  wire logic [WORD_W-1:0] commit_data,
	input  wire logic              commit_last,
	output logic                   commit_ready,
	output logic                   commit_busy
);
	localparam int CW  = $clog2(CREDITS + 1);
	localparam int BAW = (CB_DEPTH > 1) ? $clog2(CB_DEPTH) : 1;
	localparam int BCW = $clog2(CB_DEPTH + 1);

	logic [CW-1:0]     credit_reg [NUM_CH];
	logic [CW-1:0]     credit_next[NUM_CH];
	logic [1:0]        state_reg,     state_next;
	logic [WORD_W-1:0] data_reg,      data_next;
	logic              fit_reg,       fit_next;
	logic              pend_reg,      pend_next;
	logic [1:0]        pend_st_reg,   pend_st_next;
	logic [HALF_W-1:0] pend_data_reg, pend_data_next;
	logic [NUM_CH-1:0] ready_reg,     ready_next;

	logic [WORD_W-1:0] cb_mem_reg [CB_DEPTH];
	logic [WORD_W-1:0] cb_mem_next[CB_DEPTH];
	logic [BCW-1:0]    cb_cnt_reg,    cb_cnt_next;
	logic [BAW-1:0]    cb_rd_reg,     cb_rd_next;
	logic [1:0]        cb_chan_reg,   cb_chan_next;
	logic              launch_reg,    launch_next;
	logic              cready_reg,    cready_next;

	function automatic logic fits_signed16(input logic [WORD_W-1:0] w);
		return w[WORD_W-1:HALF_W] == {HALF_W{w[HALF_W-1]}};
	endfunction

	// word path and credits
	always_comb begin
		logic              have;
		logic [WORD_W-1:0] word;
		logic [1:0]        wchan;
		logic [NUM_CH-1:0] used;
		have           = 1'b0;
		word           = '0;
		wchan          = ST_NONE;
		used           = '0;
		state_next     = ST_NONE;
		data_next      = '0;
		fit_next       = 1'b0;
		pend_next      = 1'b0;
		pend_st_next   = pend_st_reg;
		pend_data_next = pend_data_reg;
		cb_mem_next    = cb_mem_reg;
		cb_cnt_next    = cb_cnt_reg;
		cb_rd_next     = cb_rd_reg;
		cb_chan_next   = cb_chan_reg;
		launch_next    = launch_reg;

		if (pend_reg) begin
			// second half owns this cycle; its credit was taken with the first
			state_next = pend_st_reg;
			data_next  = {{HALF_W{1'b0}}, pend_data_reg};
		end else if (launch_reg && credit_reg[chan_idx(cb_chan_reg)] != '0) begin
			// launched message drains ahead of any direct word
			have       = 1'b1;
			word       = cb_mem_reg[cb_rd_reg];
			wchan      = cb_chan_reg;
			cb_rd_next = cb_rd_reg + 1'b1;
			if (cb_cnt_reg == BCW'(1)) begin
				launch_next = 1'b0;
				cb_rd_next  = '0;
			end
		end else if (send_valid && send_chan != ST_NONE && ready_reg[chan_idx(send_chan)]) begin
			have  = 1'b1;
			word  = send_data;
			wchan = send_chan;
		end

		if (have) begin
			state_next             = wchan;
			used[chan_idx(wchan)]  = 1'b1;
			case (link_mode)
				MODE_NARROW: begin
					fit_next       = fits_signed16(word);
					data_next      = {{HALF_W{1'b0}}, word[HALF_W-1:0]};
					pend_next      = !fits_signed16(word);
					pend_st_next   = wchan;
					pend_data_next = word[WORD_W-1:HALF_W];
				end
				MODE_HALF: begin
					data_next      = {{HALF_W{1'b0}}, word[HALF_W-1:0]};
					pend_next      = 1'b1;
					pend_st_next   = wchan;
					pend_data_next = word[WORD_W-1:HALF_W];
				end
				default: begin
					data_next = word;
					fit_next  = 1'b1;
				end
			endcase
		end

		// filling never overlaps draining: commit_ready is low once launched
		if (commit_valid && cready_reg) begin
			cb_mem_next[cb_cnt_reg[BAW-1:0]] = commit_data;
			if (cb_cnt_reg == '0) begin
				cb_chan_next = commit_chan;
			end
			if (commit_last) begin
				launch_next = 1'b1;
			end
		end
		cb_cnt_next = cb_cnt_reg + BCW'(commit_valid && cready_reg)
			- BCW'(have && launch_reg && !pend_reg);

		// late returns from a longer off-chip hop only delay the refill
		for (int i = 0; i < NUM_CH; i++) begin
			credit_next[i] = credit_reg[i] + CW'(link.credit[i]) - CW'(used[i]);
			ready_next[i]  = credit_next[i] != '0 && !pend_next && !launch_next;
		end
		cready_next = !launch_next && cb_cnt_next < BCW'(CB_DEPTH);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CH; i++) begin
				credit_reg[i] <= CW'(CREDITS);
			end
			state_reg     <= ST_NONE;
			data_reg      <= '0;
			fit_reg       <= 1'b0;
			pend_reg      <= 1'b0;
			pend_st_reg   <= ST_NONE;
			pend_data_reg <= '0;
			ready_reg     <= '0;
		end else begin
			credit_reg    <= credit_next;
			state_reg     <= state_next;
			data_reg      <= data_next;
			fit_reg       <= fit_next;
			pend_reg      <= pend_next;
			pend_st_reg   <= pend_st_next;
			pend_data_reg <= pend_data_next;
			ready_reg     <= ready_next;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int j = 0; j < CB_DEPTH; j++) begin
				cb_mem_reg[j] <= '0;
			end
			cb_cnt_reg  <= '0;
			cb_rd_reg   <= '0;
			cb_chan_reg <= ST_MEM;
			launch_reg  <= 1'b0;
			cready_reg  <= 1'b0;
		end else begin
			cb_mem_reg  <= cb_mem_next;
			cb_cnt_reg  <= cb_cnt_next;
			cb_rd_reg   <= cb_rd_next;
			cb_chan_reg <= cb_chan_next;
			launch_reg  <= launch_next;
			cready_reg  <= cready_next;
		end
	end

	assign link.state   = state_reg;
	assign link.data    = data_reg;
	assign link.fit     = fit_reg;
	assign send_ready   = ready_reg;
	assign commit_ready = cready_reg;
	assign commit_busy  = launch_reg;
endmodule

// File: inc/chip_link_if.sv
// one direction of the chip-edge link: word path, state field, fit flag, credits
`timescale 1ns/1ps
interface chip_link_if;
	logic [1:0]  state;
	logic [31:0] data;
	logic        fit;
	logic [2:0]  credit;

	modport tx_end (
		output state,
		output data,
		output fit,
		input  credit
	);

	modport rx_end (
		input  state,
		input  data,
		input  fit,
		output credit
	);
endinterface

// File: inc/chip_link_pkg.sv
// shared constants and channel decoding for the chip-edge link
package chip_link_pkg;

	localparam int WORD_W = 32;
	localparam int HALF_W = 16;
	localparam int NUM_CH = 3;

	// merged valid and channel select carried on the state field
	localparam logic [1:0] ST_NONE   = 2'h0;
	localparam logic [1:0] ST_STATIC = 2'h1;
	localparam logic [1:0] ST_MEM    = 2'h2;
	localparam logic [1:0] ST_LOW    = 2'h3;

	// credit line positions, one per logical channel
	localparam int CR_STATIC = 0;
	localparam int CR_MEM    = 1;
	localparam int CR_LOW    = 2;

	// transfer width modes, both ends must be given the same one
	localparam logic [1:0] MODE_FULL   = 2'h0;
	localparam logic [1:0] MODE_NARROW = 2'h1;
	localparam logic [1:0] MODE_HALF   = 2'h2;

	// default depths; the sender's credit count must equal the receive depth
	localparam int RX_DEPTH_DEF = 4;
	localparam int CB_DEPTH_DEF = 8;

	// state code to credit line / buffer index; ST_NONE must not be passed
	function automatic logic [1:0] chan_idx(input logic [1:0] st);
		return st - 2'h1;
	endfunction

	function automatic logic [1:0] idx_state(input logic [1:0] idx);
		return idx + 2'h1;
	endfunction

endpackage

// File: verification/link_checker.sv
// concurrent checks on one direction of the chip-edge link
`timescale 1ns/1ps
module link_checker
	import chip_link_pkg::*;
#(
	parameter int RX_DEPTH = RX_DEPTH_DEF
) (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic [1:0]  link_mode,
	input wire logic [1:0]  state,
	input wire logic [31:0] data,
	input wire logic        fit,
	input wire logic [2:0]  credit
);
	logic       phase_reg;
	logic       phase_next;
	logic       need_second;
	logic [3:0] owed_reg [3];
	logic [3:0] owed_next [3];

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// words are counted at their first beat, so a split word owes one credit
	always_comb begin
		need_second = (state != ST_NONE) && !phase_reg &&
			(link_mode == MODE_HALF || (link_mode == MODE_NARROW && !fit));
		phase_next = need_second ? 1'b1 : ((state != ST_NONE) ? 1'b0 : phase_reg);
		for (int i = 0; i < 3; i++) begin
			owed_next[i] = owed_reg[i] - {3'h0, credit[i]};
			if (state == 2'(i + 1) && !phase_reg)
				owed_next[i] = owed_next[i] + 4'h1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= 1'b0;
			owed_reg <= '{4'h0, 4'h0, 4'h0};
		end else begin
			phase_reg <= phase_next;
			owed_reg <= owed_next;
		end
	end

	AST_FULL_FIT: assert property (link_mode == MODE_FULL && state != ST_NONE |-> fit)
		else $error("full beat without fit flag");
	AST_UPPER_ZERO: assert property (
		link_mode != MODE_FULL && state != ST_NONE |-> data[31:16] == 16'h0)
		else $error("narrow beat with upper bits set");
	AST_HALF_NOFIT: assert property (link_mode == MODE_HALF && state != ST_NONE |-> !fit)
		else $error("half beat with fit flag");
	AST_SECOND_BEAT: assert property (need_second |=> state == $past(state))
		else $error("second half missing or on other channel");
	AST_SECOND_NOFIT: assert property (need_second |=> !fit)
		else $error("second half carries fit flag");
	AST_CREDIT_ONE: assert property (credit != 3'h0 |-> $onehot(credit))
		else $error("several credits in one cycle");
	AST_NO_OVERDRAFT: assert property (
		owed_reg[0] <= RX_DEPTH && owed_reg[1] <= RX_DEPTH && owed_reg[2] <= RX_DEPTH)
		else $error("words sent beyond credits");
	AST_NO_EARLY_CREDIT: assert property (
		(!credit[0] || owed_reg[0] != 4'h0) && (!credit[1] || owed_reg[1] != 4'h0)
		&& (!credit[2] || owed_reg[2] != 4'h0))
		else $error("credit without word outstanding");
endmodule

// File: verification/test_chip_link_channel_mux.sv
// self-checking bench joining the sending and receiving ends
`timescale 1ns/1ps
module test_chip_link_channel_mux
	import chip_link_pkg::*;
;
	localparam int DEPTH = 4;
	logic        mclk = 1'b0;
	logic        rst_n, send_valid, commit_valid, commit_last;
	logic        commit_ready, commit_busy, recv_valid;
	logic [1:0]  link_mode, send_chan, commit_chan, recv_chan;
	logic [2:0]  send_ready, drain_ready;
	logic [31:0] send_data, commit_data, recv_data;
	logic [34:0] beat_q [$];
	logic [33:0] got_q [$];
	int          errors = 0, tests_run = 0, cycles = 0, cr_cnt = 0;

	chip_link_if chip_link_if_inst ();
	link_tx_end #(.CREDITS(DEPTH), .CB_DEPTH(CB_DEPTH_DEF)) link_tx_end_inst (.mclk(mclk),
		.rst_n(rst_n), .link(chip_link_if_inst), .link_mode(link_mode), .send_valid(send_valid),
		.send_chan(send_chan), .send_data(send_data), .send_ready(send_ready),
		.commit_valid(commit_valid), .commit_chan(commit_chan), .commit_data(commit_data),
		.commit_last(commit_last), .commit_ready(commit_ready), .commit_busy(commit_busy));
	link_rx_end #(.RX_DEPTH(DEPTH)) link_rx_end_inst (.mclk(mclk), .rst_n(rst_n),
		.link(chip_link_if_inst), .link_mode(link_mode), .drain_ready(drain_ready),
		.recv_valid(recv_valid), .recv_chan(recv_chan), .recv_data(recv_data));
	link_checker #(.RX_DEPTH(DEPTH)) link_checker_inst (.mclk(mclk), .rst_n(rst_n),
		.link_mode(link_mode), .state(chip_link_if_inst.state), .data(chip_link_if_inst.data),
		.fit(chip_link_if_inst.fit), .credit(chip_link_if_inst.credit));

	always #2 mclk = ~mclk;

	always @(negedge mclk) begin
		if (chip_link_if_inst.state !== ST_NONE)
			beat_q.push_back({chip_link_if_inst.state, chip_link_if_inst.fit, chip_link_if_inst.data});
		if (recv_valid === 1'b1)
			got_q.push_back({recv_chan, recv_data});
		cr_cnt += $countones(chip_link_if_inst.credit);
	end

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			give_verdict();
		end
	end

	task automatic chk(input logic [34:0] got, input logic [34:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wait_for(input int n, input bit beats);
		for (int k = 0; k < 40 && (beats ? beat_q.size() : got_q.size()) < n; k++)
			@(negedge mclk);
		chk(beats ? beat_q.size() : got_q.size(), n);
	endtask

	// ready is sampled at the falling edge, where it is settled
	task automatic send(input logic [1:0] chan, input logic [31:0] val);
		@(negedge mclk);
		send_valid = 1'b1;
		send_chan = chan;
		send_data = val;
		// bounded wait: a direct send must never block for good
		for (int k = 0; k < 40 && send_ready[chan - 2'h1] !== 1'b1; k++)
			@(negedge mclk);
		@(posedge mclk);
	endtask

	task automatic xfer(input logic [1:0] chan, input logic [31:0] val);
		logic fits;
		logic two;
		logic [31:0] lo;
		beat_q.delete();
		got_q.delete();
		send(chan, val);
		@(negedge mclk);
		send_valid = 1'b0;
		fits = (val[31:15] == 17'h0) || (val[31:15] == 17'h1FFFF);
		two = (link_mode == MODE_HALF) || (link_mode == MODE_NARROW && !fits);
		lo = (link_mode == MODE_FULL) ? val : {16'h0, val[15:0]};
		wait_for(two ? 2 : 1, 1'b1);
		chk(beat_q[0], {chan, link_mode == MODE_FULL || (link_mode == MODE_NARROW && fits), lo});
		if (two)
			chk(beat_q[1], {chan, 1'b0, 16'h0, val[31:16]});
		wait_for(1, 1'b0);
		chk(got_q[0], {1'b0, chan, val});
	endtask

	task automatic t_widths();
		logic [31:0] vals [4];
		vals = '{32'h0000_7FFF, 32'hFFFF_8000, 32'h0000_8000, 32'h8765_4321};
		for (int m = 0; m < 3; m++) begin
			@(negedge mclk);
			link_mode = 2'(m);
			for (int c = 1; c < 4; c++)
				for (int v = 0; v < 4; v++)
					xfer(2'(c), vals[v]);
		end
	endtask

	// receiver holds words back, so credits run out and return late
	task automatic t_credit();
		link_mode = MODE_FULL;
		drain_ready = 3'b110;
		got_q.delete();
		cr_cnt = 0;
		for (int k = 0; k < DEPTH; k++)
			send(ST_STATIC, 32'hC0DE_0000 + k);
		@(negedge mclk);
		send_valid = 1'b0;
		repeat (4) @(negedge mclk);
		chk(send_ready[CR_STATIC], 1'b0);
		chk(got_q.size() + cr_cnt, 0);
		drain_ready = 3'b111;
		wait_for(DEPTH, 1'b0);
		repeat (2) @(negedge mclk);
		chk(cr_cnt, DEPTH);
		chk(send_ready[CR_STATIC], 1'b1);
		for (int k = 0; k < DEPTH; k++)
			chk(got_q[k], {2'h1, 32'hC0DE_0000 + k});
	endtask

	// a direct word pressed during the drain must not split the message
	task automatic t_commit(input logic [1:0] ch);
		beat_q.delete();
		for (int k = 0; k < 3; k++) begin
			@(negedge mclk);
			commit_valid = 1'b1;
			commit_chan = ch;
			commit_data = 32'hA000_0000 + k;
			commit_last = (k == 2);
			for (int j = 0; j < 40 && commit_ready !== 1'b1; j++)
				@(negedge mclk);
			@(posedge mclk);
		end
		@(negedge mclk);
		commit_valid = 1'b0;
		commit_last = 1'b0;
		for (int k = 0; k < 10 && commit_busy !== 1'b1; k++)
			@(negedge mclk);
		chk(commit_busy, 1'b1);
		chk(commit_ready, 1'b0);
		send(ST_STATIC, 32'h5555_AAAA);
		@(negedge mclk);
		send_valid = 1'b0;
		wait_for(4, 1'b1);
		for (int k = 0; k < 3; k++)
			chk(beat_q[k], {ch, 1'b1, 32'hA000_0000 + k});
		chk(beat_q[3], {ST_STATIC, 1'b1, 32'h5555_AAAA});
		chk(commit_busy, 1'b0);
		chk(commit_ready, 1'b1);
	endtask

	initial begin
		rst_n = 1'b0;
		link_mode = MODE_FULL;
		{send_valid, commit_valid, commit_last} = 3'h0;
		{send_chan, commit_chan} = 4'h0;
		{send_data, commit_data} = 64'h0;
		drain_ready = 3'b111;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		rst_n = 1'b1;
		repeat (2) @(negedge mclk);
		t_widths();
		t_credit();
		t_commit(ST_MEM);
		t_commit(ST_LOW);
		give_verdict();
	end
endmodule
